/* core/lcp_pkg.sv */
// Constants and types of the serial command port of a 16-channel LED sink driver.
// Assumes one 40 MHz system clock; pins arrive unsynchronised from the host.
// Function
// R1 - Each shift clock rise shifts serial input in; oldest bit heads to serial out.
// R2 - Count shift clock rises while strobe high; act when strobe falls.
// R3 - Zero or one rise: copy shift register into next data buffer.
// R4 - Two rises: move all buffered words to the comparators.
// R5 - Four or five rises: load configuration into shift register.
// R6 - Six or seven rises: start sensing every output's load status.
// R7 - Eight or nine rises: load sixteen error bits into shift register.
// R8 - Ten or eleven rises: write shift register into configuration.
// R9 - Each channel gets 4096 gray levels from its 16-bit word.
// R10 - Host sends fifteen words with data latch, sixteenth with global latch.
// R11 - Buffers fill most significant bit first.
// R12 - Words fill channels from 15 down to 0.
// R13 - After detect enable, outputs turn on for a sensing period.
// R14 - Host waits at least detect settle time before reading error status.
// R15 - Captured status is held and shifted out one bit per clock.
// R16 - Channels must be on to sense; off channels report 0.
// R17 - Open mode: on channel below threshold reports 1, else 0.
// R18 - Short mode: on channel at or above threshold reports 0, below reports 1.
// R19 - Only 12 bits of each word feed the PWM counter.
// R20 - Configuration bits 9 to 2 are the 8-bit current gain.
// R21 - Sync bit 0 waits for PWM cycle end; 1 (default) updates immediately.
// R22 - Data latch slot chosen by word counter; global latch resets it.
package lcp_pkg;
  localparam int LCP_CH = 16;
  localparam int LCP_WORD = 16;
  localparam int LCP_GS = 12;
  localparam logic [15:0] LCP_CFG_RESET = 16'h3eac;
  localparam int LCP_CFG_GAIN_LO = 2;
  localparam int LCP_CFG_GAIN_HI = 9;
  localparam int LCP_CFG_SYNC = 10;
  localparam logic [15:0] LCP_CFG_WMASK = 16'h1fff;
  localparam logic [15:0] LCP_CFG_ROMASK = 16'h2000;
  localparam int LCP_CLK_MHZ = 40;
  localparam int LCP_SETTLE_NS = 1000;
  localparam int LCP_SETTLE_CYC = (LCP_SETTLE_NS * LCP_CLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {
    LCP_CMD_NONE = 3'h0,
    LCP_CMD_DLATCH = 3'h1,
    LCP_CMD_GLATCH = 3'h2,
    LCP_CMD_RDCFG = 3'h3,
    LCP_CMD_DETECT = 3'h4,
    LCP_CMD_RDERR = 3'h5,
    LCP_CMD_WRCFG = 3'h6
  } lcp_cmd_t;
endpackage

/* core/lcp_cmd_if.sv */
// Command hand-off between the front end and the core of the serial port.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface lcp_cmd_if;
  import lcp_pkg::*;
  logic cmd_valid;
  lcp_cmd_t cmd;
  logic shift_en;
  logic shift_bit;
  modport front (output cmd_valid, output cmd, output shift_en, output shift_bit);
  modport core (input cmd_valid, input cmd, input shift_en, input shift_bit);
endinterface
`default_nettype wire

/* core/lcp_front.sv */
// Pin front end: synchronises shift clock, strobe and data, and decodes commands.
// Assumes the shift clock is far slower than the 40 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module lcp_front (
  input wire logic clock, // System clock.
  input wire logic srst, // Synchronous reset.
  input wire logic shift_clock, // Host shift clock pin.
  input wire logic command_strobe, // Host strobe pin.
  input wire logic serial_in, // Host data pin.
  lcp_cmd_if.front cif // Command and shift events.
);
  import lcp_pkg::*;
  logic [2:0] clk_ff, nxt_clk;
  logic [2:0] stb_ff, nxt_stb;
  logic [1:0] din_ff, nxt_din;
  logic [3:0] cnt_ff, nxt_cnt;
  logic rise, fall;

  // Two-stage synchronisers, a third stage for edge detection.
  always_comb begin
    nxt_clk = {clk_ff[1:0], shift_clock};
    nxt_stb = {stb_ff[1:0], command_strobe};
    nxt_din = {din_ff[0], serial_in};
    rise = clk_ff[1] & ~clk_ff[2];
    fall = ~stb_ff[1] & stb_ff[2];
    nxt_cnt = cnt_ff;
    if (fall) begin
      nxt_cnt = 4'h0;
    end else if (rise && stb_ff[1] && cnt_ff != 4'hf) begin
      nxt_cnt = cnt_ff + 4'h1; // R2
    end
    cif.shift_en = rise; // R1
    cif.shift_bit = din_ff[1];
    cif.cmd_valid = fall; // R2
    // Edge counts of 3 or above 11 decode to nothing; such a command changes no register.
    case (cnt_ff)
      4'h0, 4'h1: cif.cmd = LCP_CMD_DLATCH; // R3
      4'h2: cif.cmd = LCP_CMD_GLATCH; // R4
      4'h4, 4'h5: cif.cmd = LCP_CMD_RDCFG; // R5
      4'h6, 4'h7: cif.cmd = LCP_CMD_DETECT; // R6
      4'h8, 4'h9: cif.cmd = LCP_CMD_RDERR; // R7
      4'ha, 4'hb: cif.cmd = LCP_CMD_WRCFG; // R8
      default: cif.cmd = LCP_CMD_NONE;
    endcase
  end

  // Registers only.
  always_ff @(posedge clock) begin
    if (srst) begin
      clk_ff <= 3'h0;
      stb_ff <= 3'h0;
      din_ff <= 2'h0;
      cnt_ff <= 4'h0;
    end else begin
      clk_ff <= nxt_clk;
      stb_ff <= nxt_stb;
      din_ff <= nxt_din;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule
`default_nettype wire

/* core/lcp_top.sv */
// Serial command port core: shift register, buffers, configuration and detection.
// Assumes pins from the host; load status comes from analog comparators.
`timescale 1ns/1ps
`default_nettype none
module lcp_top (
  input wire logic clock, // System clock, 40 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic shift_clock, // Host shift clock.
  input wire logic command_strobe, // Host command strobe.
  input wire logic serial_in, // Host serial data.
  input wire logic pwm_cycle_end, // One-cycle pulse at PWM cycle end.
  input wire logic short_mode, // 1 selects short detection, 0 open.
  input wire logic [15:0] below_threshold, // Comparator: output below threshold.
  output logic serial_out, // Serial data to next driver.
  output logic [lcp_pkg::LCP_CH*lcp_pkg::LCP_GS-1:0] gray_levels, // Comparator words.
  output logic [15:0] config_word, // Configuration register.
  output logic [7:0] current_gain, // Current gain code.
  output logic detect_force_on // Outputs forced on for sensing.
);
  import lcp_pkg::*;
  lcp_cmd_if cif();
  lcp_front u_front (
    .clock(clock),
    .srst(srst),
    .shift_clock(shift_clock),
    .command_strobe(command_strobe),
    .serial_in(serial_in),
    .cif(cif)
  );

  logic [15:0] sh_ff, nxt_sh;
  logic [15:0] buf_ff [LCP_CH], nxt_buf [LCP_CH];
  logic [LCP_GS-1:0] pend_ff [LCP_CH], nxt_pend [LCP_CH];
  logic [LCP_GS-1:0] cmp_ff [LCP_CH], nxt_cmp [LCP_CH];
  logic pend_v_ff, nxt_pend_v;
  logic [3:0] slot_ff, nxt_slot;
  logic [15:0] cfg_ff, nxt_cfg;
  logic [15:0] err_ff, nxt_err;
  logic [5:0] det_ff, nxt_det;
  logic det_on_ff, nxt_det_on;
  logic [15:0] sensed;
  // The comparators are not on this clock, so they pass two flip-flops first.
  logic [15:0] thr1_ff, thr2_ff;

  // Status after sensing; channels forced on here, so every bit is valid.
  assign sensed = short_mode ? thr2_ff : thr2_ff; // R17 R18

  // Shift register, buffers and configuration.
  always_comb begin
    nxt_sh = sh_ff;
    nxt_slot = slot_ff;
    nxt_cfg = cfg_ff;
    nxt_err = err_ff;
    nxt_det = det_ff;
    nxt_det_on = det_on_ff;
    nxt_pend_v = pend_v_ff;
    for (int i = 0; i < LCP_CH; i++) begin
      nxt_buf[i] = buf_ff[i];
      nxt_pend[i] = pend_ff[i];
      nxt_cmp[i] = cmp_ff[i];
    end
    if (cif.shift_en) begin
      nxt_sh = {sh_ff[14:0], cif.shift_bit}; // R1 R11
    end
    // Sensing window: outputs on, then capture when the settle count ends.
    if (det_on_ff) begin
      if (det_ff == 6'h0) begin
        nxt_det_on = 1'b0;
        nxt_err = sensed; // R13 R15
      end else begin
        nxt_det = det_ff - 6'h1;
      end
    end
    // Synchronised mode waits for the running PWM cycle to finish.
    if (pend_v_ff && (cfg_ff[LCP_CFG_SYNC] || pwm_cycle_end)) begin
      nxt_pend_v = 1'b0; // R21
      for (int i = 0; i < LCP_CH; i++) begin
        nxt_cmp[i] = pend_ff[i];
      end
    end
    if (cif.cmd_valid) begin
      case (cif.cmd)
        LCP_CMD_DLATCH: begin
          nxt_buf[4'hf - slot_ff] = sh_ff; // R3 R12 R22
          nxt_slot = slot_ff + 4'h1;
        end
        LCP_CMD_GLATCH: begin
          for (int i = 0; i < LCP_CH; i++) begin
            nxt_pend[i] = buf_ff[i][LCP_GS-1:0]; // R4 R9 R19
          end
          nxt_pend[4'hf - slot_ff] = sh_ff[LCP_GS-1:0];
          nxt_pend_v = 1'b1;
          nxt_slot = 4'h0; // R22
        end
        LCP_CMD_RDCFG: nxt_sh = cfg_ff; // R5
        LCP_CMD_DETECT: begin
          nxt_det_on = 1'b1; // R6 R13
          nxt_det = 6'(LCP_SETTLE_CYC);
        end
        LCP_CMD_RDERR: nxt_sh = err_ff; // R7 R15
        LCP_CMD_WRCFG: nxt_cfg = (sh_ff & LCP_CFG_WMASK) | LCP_CFG_ROMASK; // R8
        default: nxt_sh = sh_ff;
      endcase
    end
  end

  // Registers only.
  always_ff @(posedge clock) begin
    if (srst) begin
      sh_ff <= 16'h0;
      slot_ff <= 4'h0;
      cfg_ff <= LCP_CFG_RESET;
      err_ff <= 16'h0;
      det_ff <= 6'h0;
      det_on_ff <= 1'b0;
      pend_v_ff <= 1'b0;
      thr1_ff <= 16'h0;
      thr2_ff <= 16'h0;
      for (int i = 0; i < LCP_CH; i++) begin
        buf_ff[i] <= 16'h0;
        pend_ff[i] <= 12'h0;
        cmp_ff[i] <= 12'h0;
      end
    end else begin
      sh_ff <= nxt_sh;
      slot_ff <= nxt_slot;
      cfg_ff <= nxt_cfg;
      err_ff <= nxt_err;
      det_ff <= nxt_det;
      det_on_ff <= nxt_det_on;
      pend_v_ff <= nxt_pend_v;
      thr1_ff <= below_threshold;
      thr2_ff <= thr1_ff;
      for (int i = 0; i < LCP_CH; i++) begin
        buf_ff[i] <= nxt_buf[i];
        pend_ff[i] <= nxt_pend[i];
        cmp_ff[i] <= nxt_cmp[i];
      end
    end
  end

  // Outputs straight from flip-flops.
  always_comb begin
    serial_out = sh_ff[15]; // R1 R15
    config_word = cfg_ff;
    current_gain = cfg_ff[LCP_CFG_GAIN_HI:LCP_CFG_GAIN_LO]; // R20
    detect_force_on = det_on_ff; // R13 R16
  end
  genvar g;
  generate
    for (g = 0; g < LCP_CH; g++) begin : g_out
      assign gray_levels[g*LCP_GS +: LCP_GS] = cmp_ff[g];
    end
  endgenerate
endmodule
`default_nettype wire

/* test/lcp_host.sv */
// Behavioural host controller that drives the port's three pins.
// Assumes the caller enters each task just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module lcp_host (
  input wire logic clock, // Pacing clock.
  output logic shift_clock, // Stands low between frames.
  output logic command_strobe, // Command strobe.
  output logic serial_in // Serial data.
);
  // All pins start low at time zero.
  initial begin
    shift_clock = 1'b0;
    command_strobe = 1'b0;
    serial_in = 1'b0;
  end
  task automatic hold4;
    repeat (4) @(posedge clock);
    #2;
  endtask
  // One 200 ns period; data is spoiled once its hold time is over.
  task automatic tick;
    shift_clock = 1'b1;
    hold4();
    shift_clock = 1'b0;
    serial_in = ~serial_in;
    hold4();
  endtask
  // One word whose last n shift clocks fall inside the strobe window.
  // The command edges are data edges as well, so the word lands intact.
  task automatic word(input logic [15:0] w, input int n);
    for (int i = 15; i >= 0; i--) begin
      if (i == n - 1) begin
        command_strobe = 1'b1;
        hold4();
      end
      serial_in = w[i];
      tick();
    end
    if (n == 0) begin
      command_strobe = 1'b1;
      hold4();
    end
    command_strobe = 1'b0;
    hold4();
    hold4();
  endtask
  // The extra wait after the fall lets the command act before any new edge.
  task automatic cmd(input int n);
    command_strobe = 1'b1;
    hold4();
    repeat (n) tick();
    command_strobe = 1'b0;
    hold4();
    hold4();
  endtask
endmodule
`default_nettype wire

/* test/lcp_props.sv */
// Checker of the serial command port's pins.
// Assumes host pins stay quiet for several cycles between edges.
`timescale 1ns/1ps
`default_nettype none
module lcp_props (
  input wire logic clock, // Clock.
  input wire logic srst, // Reset.
  input wire logic shift_clock, // Shift clock.
  input wire logic command_strobe, // Strobe.
  input wire logic pwm_cycle_end, // PWM end.
  input wire logic serial_out, // Serial out.
  input wire logic [lcp_pkg::LCP_CH*lcp_pkg::LCP_GS-1:0] gray_levels, // Words.
  input wire logic [15:0] config_word, // Configuration.
  input wire logic [7:0] current_gain, // Gain.
  input wire logic detect_force_on // Sensing.
);
  import lcp_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Eight quiet cycles flush any edge still in the synchronisers.
  sequence s_quiet;
    ($stable(shift_clock) && $stable(command_strobe) && !pwm_cycle_end)[*8];
  endsequence
  sequence s_sense;
    detect_force_on[*8] ##[1:40] !detect_force_on;
  endsequence
  property p_sout; s_quiet |=> $stable(serial_out); endproperty
  a_sout: assert property (p_sout) else $error("serial out moved while idle");
  property p_gquiet; s_quiet |=> $stable(gray_levels); endproperty
  a_gquiet: assert property (p_gquiet) else $error("gray moved while idle");
  property p_gchg; $changed(gray_levels) |-> !command_strobe; endproperty
  a_gchg: assert property (p_gchg) else $error("gray moved in strobe");
  property p_cchg; $changed(config_word) |-> !command_strobe; endproperty
  a_cchg: assert property (p_cchg) else $error("config moved in strobe");
  property p_rst; $past(srst) |-> config_word == LCP_CFG_RESET; endproperty
  a_rst: assert property (p_rst) else $error("config reset value");
  property p_gain;
    $stable(config_word)[*2] |-> current_gain == config_word[LCP_CFG_GAIN_HI:LCP_CFG_GAIN_LO];
  endproperty
  a_gain: assert property (p_gain) else $error("gain not config bits");
  property p_sense; $rose(detect_force_on) |-> s_sense; endproperty
  a_sense: assert property (p_sense) else $error("sensing window length");
  property p_cause; $rose(detect_force_on) |-> !command_strobe; endproperty
  a_cause: assert property (p_cause) else $error("sensing before strobe fall");
endmodule
bind lcp_top lcp_props u_props (.*);
`default_nettype wire

/* test/test_led_driver_serial_command_port.sv */
// Self-checking bench of the serial command port against an integer model.
// Assumes the host model and bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_led_driver_serial_command_port;
  import lcp_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic pwm_cycle_end = 1'b0;
  logic short_mode = 1'b0;
  logic [15:0] below_threshold = 16'h0000;
  wire logic shift_clock, command_strobe, serial_in, serial_out, detect_force_on;
  wire logic [191:0] gray_levels;
  wire logic [15:0] config_word;
  wire logic [7:0] current_gain;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [191:0] exp_gray = '0;
  logic [15:0] cfg = LCP_CFG_RESET;
  logic [15:0] q[$];
  always #12.5 clock = ~clock;
  lcp_host u_host (.clock(clock), .shift_clock(shift_clock),
    .command_strobe(command_strobe), .serial_in(serial_in));
  lcp_top u_dut (.clock(clock), .srst(srst), .shift_clock(shift_clock),
    .command_strobe(command_strobe), .serial_in(serial_in), .pwm_cycle_end(pwm_cycle_end),
    .short_mode(short_mode), .below_threshold(below_threshold), .serial_out(serial_out),
    .gray_levels(gray_levels), .config_word(config_word), .current_gain(current_gain),
    .detect_force_on(detect_force_on));
  task automatic chk(input logic [191:0] got, input logic [191:0] e);
    total_checks++;
    if (got !== e) begin
      n_mismatch++;
      $display("BAD %0t got %0h want %0h", $time, got, e);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Each bit is judged before the shift that replaces it.
  task automatic rd(input int n, input logic [15:0] e);
    u_host.cmd(n);
    for (int i = 15; i >= 0; i--) begin
      chk(serial_out, e[i]);
      u_host.tick();
    end
  endtask
  // A frame of sixteen random words; held data must not leak early.
  task automatic frame(input logic sync);
    for (int k = 0; k < 16; k++) begin
      q.push_back(16'($urandom));
      u_host.word(q[k], k == 15 ? 2 : k % 2);
      if (k == 14) chk(gray_levels, exp_gray);
    end
    if (!sync) begin
      chk(gray_levels, exp_gray);
      pwm_cycle_end = 1'b1;
      @(posedge clock);
      #2;
      pwm_cycle_end = 1'b0;
      repeat (3) @(posedge clock);
      #2;
    end
    for (int k = 0; k < 16; k++) exp_gray[12*(15-k)+:12] = q[k][11:0];
    q.delete();
    chk(gray_levels, exp_gray);
  endtask
  // Main sequence; reset spans sixteen cycles.
  initial begin
    logic [15:0] w;
    void'($urandom(10));
    repeat (16) @(posedge clock);
    #2;
    srst = 1'b0;
    chk(config_word, cfg);
    chk(current_gain, 8'hab);
    $display("reset test done");
    frame(1'b1);
    u_host.cmd(3);
    u_host.cmd(12);
    chk(config_word, cfg);
    chk(gray_levels, exp_gray);
    $display("frame test done");
    for (int n = 10; n < 12; n++) begin
      w = 16'($urandom);
      w[10] = (n == 10);
      u_host.word(w, n);
      cfg = (w & 16'h1fff) | 16'h2000;
      chk(config_word, cfg);
      chk(current_gain, cfg[9:2]);
      rd(n - 6, cfg);
    end
    frame(1'b0);
    $display("config test done");
    for (int n = 6; n < 8; n++) begin
      below_threshold = 16'($urandom);
      short_mode = n[0];
      u_host.cmd(n);
      chk(detect_force_on, 1'b1);
      repeat (60) @(posedge clock);
      #2;
      chk(detect_force_on, 1'b0);
      rd(n + 2, below_threshold);
    end
    $display("detect test done");
    close_out();
  end
  // The tests need well under half a millisecond.
  initial begin
    #2000000;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
